// [verification/servo_home_status_asserts.sv]
// concurrent checks on the ports of the homing and torque status block
`timescale 1ns/10ps
module servo_home_status_asserts
  import servo_home_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic OD_WRITE,
  input wire logic OD_READ,
  input wire logic [15:0] OD_INDEX,
  input wire logic [7:0] OD_SUBINDEX,
  input wire logic [31:0] OD_WDATA,
  input wire logic OD_ACK,
  input wire logic OD_ABORT,
  input wire logic MOTOR_RUN,
  input wire logic [31:0] SPEED_COMMAND,
  input wire logic HALT_ACTIVE,
  input wire logic TORQUE_REACHED,
  input wire logic HOME_SEARCH_TIMEOUT_ALARM,
  input wire logic POSITION_PRESET,
  input wire logic [15:0] STATUS_WORD
);
  // ==========================================================
  // helpers
  wire ctrl_wr = OD_WRITE && OD_INDEX == IDX_CTRL && OD_SUBINDEX == SUB_ZERO;
  wire any_acc = OD_WRITE || OD_READ;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  // ==========================================================
  // object port answer
  AST_ANSWER: assert property (any_acc |=> (OD_ACK || OD_ABORT))
    else $error("access got no answer");
  AST_QUIET: assert property (!any_acc |=> !(OD_ACK || OD_ABORT))
    else $error("answer without access");

  // ==========================================================
  // run enable and motion
  AST_RUN_ON: assert property (
    ctrl_wr && OD_WDATA[3:0] == CW_RUN_MASK ##1 !ctrl_wr |=> MOTOR_RUN)
    else $error("motor not running with enable bits set");
  AST_RUN_OFF: assert property (
    ctrl_wr && OD_WDATA[3:0] != CW_RUN_MASK ##1 !ctrl_wr |=> !MOTOR_RUN)
    else $error("motor running without all enable bits");
  AST_STILL_OFF: assert property (!MOTOR_RUN [*2] |-> SPEED_COMMAND == 32'h0)
    else $error("speed commanded while disabled");
  AST_OP_SHOWN: assert property (MOTOR_RUN [*2] |-> STATUS_WORD[SW_OP_ENABLED])
    else $error("operation enabled bit missing");
  AST_HALT_STOP: assert property (HALT_ACTIVE [*2] |-> SPEED_COMMAND == 32'h0)
    else $error("speed commanded during halt");

  // ==========================================================
  // status flags
  AST_TQ_FLAG: assert property (TORQUE_REACHED [*2] |-> STATUS_WORD[SW_REACHED])
    else $error("torque reached not in status");
  AST_ALARM_ERR: assert property (
    $rose(HOME_SEARCH_TIMEOUT_ALARM) |-> ##[0:1] STATUS_WORD[SW_HOME_ERR])
    else $error("timeout alarm without homing error");
  AST_DONE_FLAGS: assert property (
    POSITION_PRESET |-> ##[1:2] (STATUS_WORD[SW_REACHED] && STATUS_WORD[SW_ATTAINED]))
    else $error("home found without attained flags");
  AST_DONE_STOP: assert property (
    POSITION_PRESET |=> SPEED_COMMAND == 32'h0 && !POSITION_PRESET)
    else $error("motor not stopped at home");

  C_PRESET: cover property (POSITION_PRESET);
  C_ALARM: cover property ($rose(HOME_SEARCH_TIMEOUT_ALARM));
  C_TORQUE: cover property ($rose(TORQUE_REACHED));
  C_HALT: cover property (HALT_ACTIVE [*2]);
endmodule : servo_home_status_asserts

bind servo_home_status servo_home_status_asserts u_asserts (
  .CLK(CLK), .RSTN(RSTN), .OD_WRITE(OD_WRITE), .OD_READ(OD_READ),
  .OD_INDEX(OD_INDEX), .OD_SUBINDEX(OD_SUBINDEX), .OD_WDATA(OD_WDATA),
  .OD_ACK(OD_ACK), .OD_ABORT(OD_ABORT), .MOTOR_RUN(MOTOR_RUN),
  .SPEED_COMMAND(SPEED_COMMAND), .HALT_ACTIVE(HALT_ACTIVE),
  .TORQUE_REACHED(TORQUE_REACHED), .HOME_SEARCH_TIMEOUT_ALARM(HOME_SEARCH_TIMEOUT_ALARM),
  .POSITION_PRESET(POSITION_PRESET), .STATUS_WORD(STATUS_WORD));

// [verification/servo_host_model.sv]
// host controller model issuing object accesses
`timescale 1ns/10ps
module servo_host_model
(
  input wire logic CLK,
  output logic OD_WRITE,
  output logic OD_READ,
  output logic [15:0] OD_INDEX,
  output logic [7:0] OD_SUBINDEX,
  output logic [31:0] OD_WDATA,
  input wire logic OD_ACK,
  input wire logic OD_ABORT,
  input wire logic [31:0] OD_RDATA
);
  initial {OD_WRITE, OD_READ, OD_INDEX, OD_SUBINDEX, OD_WDATA} = 58'h0;

  // ==========================================================
  // cyclic object access
  // strobe is a one-cycle pulse; answer lands one edge later
  task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] d, output logic ack, output logic abt, output logic [31:0] rd);
    @(posedge CLK);
    OD_WRITE <= w;
    OD_READ <= !w;
    OD_INDEX <= i;
    OD_SUBINDEX <= s;
    OD_WDATA <= d;
    @(posedge CLK);
    // released lines must not keep the old value
    OD_WRITE <= 1'b0;
    OD_READ <= 1'b0;
    OD_INDEX <= ~i;
    OD_SUBINDEX <= ~s;
    OD_WDATA <= ~d;
    #1;
    ack = OD_ACK;
    abt = OD_ABORT;
    rd = OD_RDATA;
  endtask : xfer
endmodule : servo_host_model

// [verification/tb_top.sv]
// self-checking bench of the homing and torque status block
`timescale 1ns/10ps
module tb_top
  import servo_home_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  wire od_write, od_read, od_ack, od_abort;
  wire [15:0] od_index;
  wire [7:0] od_sub;
  wire [31:0] od_wdata, od_rdata, speed_cmd, preset_value;
  wire motor_run, halt_active, torque_reached, alarm, preset;
  wire [15:0] halt_option, status_word;
  logic [15:0] torque_act = 16'h0000;
  logic [31:0] following_err = 32'h0;
  logic enc_idx = 1'b0;
  logic neg_lim = 1'b0;
  logic home_sw = 1'b0;
  int errors = 0;
  int samples_checked = 0;
  logic [15:0] d_idx [11] = '{16'h2001, 16'h2002, 16'h6067, 16'h6099, 16'h6099,
    16'h6040, 16'h6060, 16'h6098, 16'h603F, 16'h609A, 16'h6065};
  logic [7:0] d_sub [11] = '{8'h1E, 8'h26, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  logic [31:0] d_val [11] = '{32'h2710, 32'h0, 32'h2DE, 32'h1F4, 32'hC8, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h10000};
  // gaps to target 0x64 with range 0x0A: 20, 5, -10, -20, 10, 0
  logic [15:0] tq_v [6] = '{16'h0078, 16'h0069, 16'h005A, 16'h0050, 16'h006E, 16'h0064};
  logic tq_e [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  servo_host_model u_host (.CLK(clk), .OD_WRITE(od_write), .OD_READ(od_read),
    .OD_INDEX(od_index), .OD_SUBINDEX(od_sub), .OD_WDATA(od_wdata), .OD_ACK(od_ack),
    .OD_ABORT(od_abort), .OD_RDATA(od_rdata));

  // short millisecond keeps the timeout run brief
  servo_home_status #(.MS_CYCLES(4)) u_dut (.CLK(clk), .RSTN(rstn), .OD_WRITE(od_write),
    .OD_READ(od_read), .OD_INDEX(od_index), .OD_SUBINDEX(od_sub), .OD_WDATA(od_wdata),
    .OD_RDATA(od_rdata), .OD_ACK(od_ack), .OD_ABORT(od_abort), .TORQUE_ACTUAL(torque_act),
    .POSITION_ACTUAL(32'h0001_2345), .SPEED_ACTUAL(32'h0000_0BB8),
    .FOLLOWING_ERROR(following_err), .ENCODER_INDEX(enc_idx),
    .NEGATIVE_TRAVEL_LIMIT_INPUT(neg_lim), .HOME_SWITCH_INPUT(home_sw),
    .MOTOR_RUN(motor_run), .SPEED_COMMAND(speed_cmd), .HALT_ACTIVE(halt_active),
    .HALT_OPTION(halt_option), .TORQUE_REACHED(torque_reached),
    .HOME_SEARCH_TIMEOUT_ALARM(alarm), .POSITION_PRESET(preset),
    .POSITION_PRESET_VALUE(preset_value), .STATUS_WORD(status_word));

  // ==========================================================
  // tasks
  task automatic tally_and_finish();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] d, input logic ab, input logic [31:0] e);
    logic ack;
    logic abt;
    logic [31:0] rdat;
    u_host.xfer(w, i, s, d, ack, abt, rdat);
    chk({30'h0, ack, abt}, {30'h0, !ab, ab});
    if (!w && !ab)
      chk(rdat, e);
  endtask : acc

  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
    acc(1'b1, i, s, d, 1'b0, 32'h0);
  endtask : wr

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic pins(input logic l, input logic h, input logic z);
    @(posedge clk);
    neg_lim <= l;
    home_sw <= h;
    enc_idx <= z;
  endtask : pins

  task automatic start_home();
    wr(IDX_CTRL, SUB_ZERO, 32'h0F);
    wr(IDX_CTRL, SUB_ZERO, 32'h1F);
    cyc(3);
  endtask : start_home

  // waits for the home-found pulse, index pulse applied first
  task automatic find_home(input logic [31:0] ofs);
    int k;
    pins(1'b0, 1'b0, 1'b1);
    for (k = 0; k < 50; k++)
    begin
      cyc(1);
      if (preset === 1'b1)
        break;
    end
    // missed pulse counts; run goes on to the report
    if (k == 50)
      errors++;
    chk(preset_value, ofs);
    pins(1'b0, 1'b0, 1'b0);
    cyc(2);
    chk({30'h0, status_word[SW_ATTAINED], status_word[SW_REACHED]}, 32'h3);
    chk(speed_cmd, 32'h0);
  endtask : find_home

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int n = 0; n < 11; n++)
      acc(1'b0, d_idx[n], d_sub[n], 32'h0, 1'b0, d_val[n]);
    acc(1'b0, 16'h1234, SUB_ZERO, 32'h0, 1'b1, 32'h0);
    acc(1'b1, IDX_STAT, SUB_ZERO, 32'h1, 1'b1, 32'h0);
    acc(1'b0, IDX_POS_FB, SUB_ZERO, 32'h0, 1'b0, 32'h0001_2345);
    acc(1'b0, IDX_SPEED_ACT, SUB_ZERO, 32'h0, 1'b0, 32'h0000_0BB8);
    // torque mode flag
    wr(IDX_MODE_SEL, SUB_ZERO, 32'h0A);
    wr(IDX_TQ_TARGET, SUB_ZERO, 32'h64);
    wr(IDX_TQ_RANGE, SUB_TQ_RANGE, 32'h0A);
    for (int n = 0; n < 6; n++)
    begin
      @(posedge clk);
      torque_act <= tq_v[n];
      cyc(4);
      chk({31'h0, torque_reached}, {31'h0, tq_e[n]});
      chk({31'h0, status_word[SW_REACHED]}, {31'h0, tq_e[n]});
    end
    start_home();
    chk(speed_cmd, 32'h0);
    chk({30'h0, motor_run, status_word[SW_OP_ENABLED]}, 32'h3);
    // method 1, negative limit
    wr(IDX_MODE_SEL, SUB_ZERO, 32'h06);
    wr(IDX_METHOD, SUB_ZERO, 32'h01);
    wr(IDX_HOME_OFS, SUB_ZERO, 32'h1234);
    start_home();
    chk(speed_cmd, 32'hFFFF_FE0C);
    pins(1'b1, 1'b0, 1'b0);
    cyc(5);
    chk(speed_cmd, 32'h0000_00C8);
    pins(1'b0, 1'b0, 1'b0);
    cyc(5);
    find_home(32'h1234);
    // method 3, home switch, with halt
    wr(IDX_METHOD, SUB_ZERO, 32'h03);
    wr(IDX_HALT_OPT, SUB_ZERO, 32'h02);
    start_home();
    chk(speed_cmd, 32'h0000_01F4);
    chk({31'h0, status_word[SW_ATTAINED]}, 32'h0);
    chk({16'h0, halt_option}, 32'h2);
    wr(IDX_CTRL, SUB_ZERO, 32'h11F);
    cyc(3);
    chk({31'h0, halt_active}, 32'h1);
    chk(speed_cmd, 32'h0);
    wr(IDX_CTRL, SUB_ZERO, 32'h1F);
    cyc(3);
    chk(speed_cmd, 32'h0000_01F4);
    pins(1'b0, 1'b1, 1'b0);
    cyc(5);
    chk(speed_cmd, 32'hFFFF_FF38);
    // index before the switch falls must not stop the search
    pins(1'b0, 1'b1, 1'b1);
    cyc(5);
    pins(1'b0, 1'b1, 1'b0);
    cyc(5);
    chk(speed_cmd, 32'hFFFF_FF38);
    pins(1'b0, 1'b0, 1'b0);
    cyc(5);
    find_home(32'h1234);
    // timeout after 3 ms of 4 cycles
    wr(IDX_DURATION, SUB_DURATION, 32'h03);
    wr(IDX_METHOD, SUB_ZERO, 32'h01);
    start_home();
    chk({31'h0, alarm}, 32'h0);
    cyc(30);
    chk({30'h0, alarm, status_word[SW_HOME_ERR]}, 32'h3);
    acc(1'b0, IDX_FAULT, SUB_ZERO, 32'h0, 1'b0, 32'h35);
    wr(IDX_CTRL, SUB_ZERO, 32'h0F);
    cyc(3);
    chk(speed_cmd, 32'h0);
    // excessive deviation: error without alarm
    @(posedge clk);
    following_err <= 32'h0002_0000;
    wr(IDX_CTRL, SUB_ZERO, 32'h1F);
    cyc(6);
    chk({30'h0, alarm, status_word[SW_HOME_ERR]}, 32'h1);
    @(posedge clk);
    following_err <= 32'h0;
    wr(IDX_CTRL, SUB_ZERO, 32'h0E);
    cyc(3);
    chk({31'h0, motor_run}, 32'h0);
    tally_and_finish();
  end
endmodule : tb_top

// [verilog/servo_home_pkg.sv]
// constants, object indices and field layouts of the homing and torque status block
// Functional notes
// - torque gap above range sets reached flag
// - torque gap below range clears reached flag
// - home equals machine zero plus offset
// - encoder index is home; stop there
// - motor runs only with control bits 0-3
// - bit4 rise starts, fall ends homing
// - halt bit stops motion per halt option; speed command goes to zero for every option, the option is only passed out
// - homing mode bit10 shows target reached
// - bit12 shows homing success when reached
// - bit13 flags timeout or excessive deviation
// - homing over duration raises timeout alarm
// - fast search uses first homing speed
// - slow approach uses second homing speed
// - method 1 uses negative limit switch
// - method 3 uses home switch
package servo_home_pkg;

  // ==========================================================
  // object dictionary indices and subindices
  localparam logic [15:0] IDX_DURATION = 16'h2001;
  localparam logic [7:0] SUB_DURATION = 8'h1E;
  localparam logic [15:0] IDX_TQ_RANGE = 16'h2002;
  localparam logic [7:0] SUB_TQ_RANGE = 8'h26;
  localparam logic [15:0] IDX_FAULT = 16'h603F;
  localparam logic [15:0] IDX_CTRL = 16'h6040;
  localparam logic [15:0] IDX_STAT = 16'h6041;
  localparam logic [15:0] IDX_HALT_OPT = 16'h605D;
  localparam logic [15:0] IDX_MODE_SEL = 16'h6060;
  localparam logic [15:0] IDX_MODE_SHOW = 16'h6061;
  localparam logic [15:0] IDX_POS_ACT = 16'h6062;
  localparam logic [15:0] IDX_POS_FB = 16'h6064;
  localparam logic [15:0] IDX_FOLLOW_LIM = 16'h6065;
  localparam logic [15:0] IDX_POS_THR = 16'h6067;
  localparam logic [15:0] IDX_POS_WIN = 16'h6068;
  localparam logic [15:0] IDX_SPEED_ACT = 16'h606C;
  localparam logic [15:0] IDX_TQ_TARGET = 16'h6071;
  localparam logic [15:0] IDX_TQ_ACT = 16'h6077;
  localparam logic [15:0] IDX_HOME_OFS = 16'h607C;
  localparam logic [15:0] IDX_METHOD = 16'h6098;
  localparam logic [15:0] IDX_SPEEDS = 16'h6099;
  localparam logic [7:0] SUB_FAST = 8'h01;
  localparam logic [7:0] SUB_SLOW = 8'h02;
  localparam logic [15:0] IDX_ACCEL = 16'h609A;
  localparam logic [15:0] IDX_FOLLOW_ERR = 16'h60F4;
  localparam logic [7:0] SUB_ZERO = 8'h00;

  // ==========================================================
  // reset values and the homing timeout fault code
  localparam logic [15:0] RST_DURATION = 16'h2710;
  localparam logic [15:0] RST_TQ_RANGE = 16'h0000;
  localparam logic [31:0] RST_POS_THR = 32'h0000_02DE;
  localparam logic [15:0] RST_FAST = 16'h01F4;
  localparam logic [15:0] RST_SLOW = 16'h00C8;
  localparam logic [31:0] RST_FOLLOW_LIM = 32'h0001_0000;
  localparam logic [15:0] FAULT_HOME_TIMEOUT = 16'h0035;

  // ==========================================================
  // control word and status word bit positions
  localparam int CW_HOME_START = 4;
  localparam int CW_HALT = 8;
  localparam logic [3:0] CW_RUN_MASK = 4'hF;
  localparam int SW_OP_ENABLED = 2;
  localparam int SW_REACHED = 10;
  localparam int SW_ATTAINED = 12;
  localparam int SW_HOME_ERR = 13;

  // ==========================================================
  // modes and homing methods
  localparam logic [7:0] MODE_HOMING = 8'h06;
  localparam logic [7:0] MODE_TORQUE = 8'h0A;
  localparam logic [15:0] METHOD_NEG_LIMIT = 16'h0001;
  localparam logic [15:0] METHOD_HOME_SW = 16'h0003;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLE_COUNT = MS_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [5:0] {
    HS_IDLE = 6'b000001,
    HS_FAST = 6'b000010,
    HS_SLOW = 6'b000100,
    HS_INDEX = 6'b001000,
    HS_DONE = 6'b010000,
    HS_FAIL = 6'b100000
  } home_state_type;

endpackage : servo_home_pkg

// [verilog/servo_home_status.sv]
// homing sequencer, torque-reached flag and object dictionary of the servo drive
`timescale 1ns/10ps
module servo_home_status
  import servo_home_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLE_COUNT
)
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic OD_WRITE,
  input wire logic OD_READ,
  input wire logic [15:0] OD_INDEX,
  input wire logic [7:0] OD_SUBINDEX,
  input wire logic [31:0] OD_WDATA,
  output logic [31:0] OD_RDATA,
  output logic OD_ACK,
  output logic OD_ABORT,
  input wire logic [15:0] TORQUE_ACTUAL,
  input wire logic [31:0] POSITION_ACTUAL,
  input wire logic [31:0] SPEED_ACTUAL,
  input wire logic [31:0] FOLLOWING_ERROR,
  input wire logic ENCODER_INDEX,
  input wire logic NEGATIVE_TRAVEL_LIMIT_INPUT,
  input wire logic HOME_SWITCH_INPUT,
  output logic MOTOR_RUN,
  output logic [31:0] SPEED_COMMAND,
  output logic HALT_ACTIVE,
  output logic [15:0] HALT_OPTION,
  output logic TORQUE_REACHED,
  output logic HOME_SEARCH_TIMEOUT_ALARM,
  output logic POSITION_PRESET,
  output logic [31:0] POSITION_PRESET_VALUE,
  output logic [15:0] STATUS_WORD
);

  // ==========================================================
  // storage
  logic [15:0] duration_reg, tq_range_reg, fault_reg, ctrl_reg, halt_opt_reg, pos_win_reg;
  logic [15:0] tq_target_reg, method_reg, fast_reg, slow_reg, accel_reg;
  logic [15:0] ms_div_reg, ms_count_reg;
  logic [31:0] follow_lim_reg, pos_thr_reg, home_ofs_reg;
  logic [7:0] mode_reg;
  home_state_type state_reg, state_next;
  logic dir_neg_reg, dir_neg_next, attained_reg, home_err_reg, tq_reached_reg, start_prev_reg;
  logic [2:0] sync_reg, sync_mid_reg, pin_prev_reg;

  // ==========================================================
  // pin synchronisers: index, negative limit, home switch
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sync_mid_reg <= 3'h0;
      sync_reg <= 3'h0;
      pin_prev_reg <= 3'h0;
    end
    else
    begin
      sync_mid_reg <= {HOME_SWITCH_INPUT, NEGATIVE_TRAVEL_LIMIT_INPUT, ENCODER_INDEX};
      sync_reg <= sync_mid_reg;
      pin_prev_reg <= sync_reg;
    end
  end

  wire [2:0] pin_rise = sync_reg & ~pin_prev_reg;
  wire [2:0] pin_fall = ~sync_reg & pin_prev_reg;
  wire index_rise = pin_rise[0];

  // ==========================================================
  // object decode
  wire sub0 = (OD_SUBINDEX == SUB_ZERO);
  wire hit_duration = (OD_INDEX == IDX_DURATION) && (OD_SUBINDEX == SUB_DURATION);
  wire hit_tq_range = (OD_INDEX == IDX_TQ_RANGE) && (OD_SUBINDEX == SUB_TQ_RANGE);
  wire hit_fault = (OD_INDEX == IDX_FAULT) && sub0;
  wire hit_ctrl = (OD_INDEX == IDX_CTRL) && sub0;
  wire hit_stat = (OD_INDEX == IDX_STAT) && sub0;
  wire hit_halt = (OD_INDEX == IDX_HALT_OPT) && sub0;
  wire hit_mode = (OD_INDEX == IDX_MODE_SEL) && sub0;
  wire hit_mshow = (OD_INDEX == IDX_MODE_SHOW) && sub0;
  wire hit_pos_act = (OD_INDEX == IDX_POS_ACT) && sub0;
  wire hit_pos_fb = (OD_INDEX == IDX_POS_FB) && sub0;
  wire hit_flim = (OD_INDEX == IDX_FOLLOW_LIM) && sub0;
  wire hit_pthr = (OD_INDEX == IDX_POS_THR) && sub0;
  wire hit_pwin = (OD_INDEX == IDX_POS_WIN) && sub0;
  wire hit_spd = (OD_INDEX == IDX_SPEED_ACT) && sub0;
  wire hit_tq_tgt = (OD_INDEX == IDX_TQ_TARGET) && sub0;
  wire hit_tq_act = (OD_INDEX == IDX_TQ_ACT) && sub0;
  wire hit_hofs = (OD_INDEX == IDX_HOME_OFS) && sub0;
  wire hit_method = (OD_INDEX == IDX_METHOD) && sub0;
  wire hit_fast = (OD_INDEX == IDX_SPEEDS) && (OD_SUBINDEX == SUB_FAST);
  wire hit_slow = (OD_INDEX == IDX_SPEEDS) && (OD_SUBINDEX == SUB_SLOW);
  wire hit_accel = (OD_INDEX == IDX_ACCEL) && sub0;
  wire hit_ferr = (OD_INDEX == IDX_FOLLOW_ERR) && sub0;

  wire hit_rw = hit_duration | hit_tq_range | hit_ctrl | hit_halt | hit_mode | hit_flim
    | hit_pthr | hit_pwin | hit_tq_tgt | hit_hofs | hit_method | hit_fast | hit_slow | hit_accel;
  wire hit_ro = hit_fault | hit_stat | hit_mshow | hit_pos_act | hit_pos_fb | hit_spd
    | hit_tq_act | hit_ferr;
  wire wr = OD_WRITE & hit_rw;

  // ==========================================================
  // homing conditions
  // all four enable bits
  wire enabled = (ctrl_reg[3:0] == CW_RUN_MASK);
  wire halt = ctrl_reg[CW_HALT];
  wire home_mode = (mode_reg == MODE_HOMING);
  wire start_bit = ctrl_reg[CW_HOME_START];
  // rise starts only when selected and enabled
  wire start_req = start_bit & ~start_prev_reg & ~halt & home_mode & enabled;
  // falling start bit ends the run
  wire end_req = ~start_bit & start_prev_reg;
  wire searching = (state_reg == HS_FAST) | (state_reg == HS_SLOW) | (state_reg == HS_INDEX);
  wire method_ok = (method_reg == METHOD_NEG_LIMIT) | (method_reg == METHOD_HOME_SW);
  // method 1 watches the negative limit, method 3 the home switch
  wire use_limit = (method_reg == METHOD_NEG_LIMIT);
  wire decel_level = use_limit ? sync_reg[1] : sync_reg[2];
  wire decel_rise = use_limit ? pin_rise[1] : pin_rise[2];
  wire decel_fall = use_limit ? pin_fall[1] : pin_fall[2];

  // ==========================================================
  // homing duration timer, milliseconds
  wire ms_tick = (ms_div_reg == 16'(MS_CYCLES - 1));
  wire timed_out = searching & (ms_count_reg >= duration_reg);
  wire [31:0] ferr_abs = FOLLOWING_ERROR[31] ? (32'h0 - FOLLOWING_ERROR) : FOLLOWING_ERROR;
  wire deviation = searching & (ferr_abs > follow_lim_reg);
  // timeout or deviation is a homing error
  wire home_fail = timed_out | deviation;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ms_div_reg <= 16'h0;
      ms_count_reg <= 16'h0;
    end
    else if (start_req || !searching)
    begin
      ms_div_reg <= 16'h0;
      ms_count_reg <= 16'h0;
    end
    else if (!halt)
    begin
      ms_div_reg <= ms_tick ? 16'h0 : ms_div_reg + 16'h1;
      if (ms_tick && ms_count_reg != 16'hFFFF)
        ms_count_reg <= ms_count_reg + 16'h1;
    end
  end

  // ==========================================================
  // homing sequencer
  always_comb
  begin
    state_next = state_reg;
    dir_neg_next = dir_neg_reg;
    case (state_reg)
      HS_IDLE, HS_DONE, HS_FAIL:
      begin
        if (start_req && method_ok)
        begin
          // switch already active goes straight to slow positive
          if (decel_level)
          begin
            state_next = HS_SLOW;
            dir_neg_next = 1'b0;
          end
          else
          begin
            state_next = HS_FAST;
            dir_neg_next = use_limit;
          end
        end
      end
      HS_FAST:
      begin
        // rising edge reverses at slow speed
        if (decel_rise)
        begin
          state_next = HS_SLOW;
          dir_neg_next = ~dir_neg_reg;
        end
      end
      HS_SLOW:
        if (decel_fall)
          state_next = HS_INDEX;
      HS_INDEX:
        if (index_rise)
          state_next = HS_DONE;
      default:
        state_next = HS_IDLE;
    endcase
    // halted motion resumes where it stopped
    if (searching && home_fail)
      state_next = HS_FAIL;
    else if (searching && (end_req || !enabled || !home_mode))
      state_next = HS_IDLE;
    else if (searching && halt)
      state_next = state_reg;
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_reg <= HS_IDLE;
      dir_neg_reg <= 1'b0;
      start_prev_reg <= 1'b0;
      attained_reg <= 1'b0;
      home_err_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      dir_neg_reg <= dir_neg_next;
      start_prev_reg <= start_bit;
      // new run clears, home point sets
      if (start_req)
        attained_reg <= 1'b0;
      else if (state_next == HS_DONE && state_reg == HS_INDEX)
        attained_reg <= 1'b1;
      if (start_req)
        home_err_reg <= 1'b0;
      else if (state_next == HS_FAIL && searching)
        home_err_reg <= 1'b1;
    end
  end

  // ==========================================================
  // torque reached: equal gap holds the previous verdict
  wire [16:0] tq_diff = {TORQUE_ACTUAL[15], TORQUE_ACTUAL} - {tq_target_reg[15], tq_target_reg};
  wire [16:0] tq_gap = tq_diff[16] ? (17'h0 - tq_diff) : tq_diff;
  wire torque_mode = (mode_reg == MODE_TORQUE);
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      tq_reached_reg <= 1'b0;
    else if (!torque_mode)
      tq_reached_reg <= 1'b0;
    else if (tq_gap > {1'b0, tq_range_reg})
      tq_reached_reg <= 1'b1;
    else if (tq_gap < {1'b0, tq_range_reg})
      tq_reached_reg <= 1'b0;
  end

  // ==========================================================
  // status word
  // stopped homing run means target reached
  wire reached_bit = torque_mode ? tq_reached_reg : (home_mode & ~searching);
  // success bit only meaningful once reached
  wire attained_bit = home_mode & enabled & reached_bit & attained_reg;
  wire [15:0] status_next = {2'b00, home_err_reg, attained_bit, 1'b0, reached_bit, 7'h00,
    enabled, 2'b00};
  wire [15:0] speed_mag = (state_reg == HS_FAST) ? fast_reg : slow_reg;
  wire moving = searching & enabled & ~halt;
  wire [31:0] speed_next = !moving ? 32'h0 :
    (dir_neg_reg ? (32'h0 - {16'h0, speed_mag}) : {16'h0, speed_mag});

  // ==========================================================
  // object read mux
  wire [31:0] rd_mux =
    hit_duration ? {16'h0, duration_reg} :
    hit_tq_range ? {16'h0, tq_range_reg} :
    hit_fault ? {16'h0, fault_reg} :
    hit_ctrl ? {16'h0, ctrl_reg} :
    hit_stat ? {16'h0, status_next} :
    hit_halt ? {16'h0, halt_opt_reg} :
    (hit_mode | hit_mshow) ? {24'h0, mode_reg} :
    (hit_pos_act | hit_pos_fb) ? POSITION_ACTUAL :
    hit_flim ? follow_lim_reg :
    hit_pthr ? pos_thr_reg :
    hit_pwin ? {16'h0, pos_win_reg} :
    hit_spd ? SPEED_ACTUAL :
    hit_tq_tgt ? {16'h0, tq_target_reg} :
    hit_tq_act ? {16'h0, TORQUE_ACTUAL} :
    hit_hofs ? home_ofs_reg :
    hit_method ? {16'h0, method_reg} :
    hit_fast ? {16'h0, fast_reg} :
    hit_slow ? {16'h0, slow_reg} :
    hit_accel ? {16'h0, accel_reg} :
    hit_ferr ? FOLLOWING_ERROR : 32'h0;

  // ==========================================================
  // object storage and registered outputs
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      duration_reg <= RST_DURATION;
      tq_range_reg <= RST_TQ_RANGE;
      fault_reg <= 16'h0;
      ctrl_reg <= 16'h0;
      halt_opt_reg <= 16'h0;
      mode_reg <= 8'h0;
      follow_lim_reg <= RST_FOLLOW_LIM;
      pos_thr_reg <= RST_POS_THR;
      pos_win_reg <= 16'h0;
      tq_target_reg <= 16'h0;
      home_ofs_reg <= 32'h0;
      method_reg <= 16'h0;
      fast_reg <= RST_FAST;
      slow_reg <= RST_SLOW;
      accel_reg <= 16'h0;
      OD_RDATA <= 32'h0;
      OD_ACK <= 1'b0;
      OD_ABORT <= 1'b0;
      MOTOR_RUN <= 1'b0;
      SPEED_COMMAND <= 32'h0;
      HALT_ACTIVE <= 1'b0;
      HALT_OPTION <= 16'h0;
      TORQUE_REACHED <= 1'b0;
      HOME_SEARCH_TIMEOUT_ALARM <= 1'b0;
      POSITION_PRESET <= 1'b0;
      POSITION_PRESET_VALUE <= 32'h0;
      STATUS_WORD <= 16'h0;
    end
    else
    begin
      if (wr && hit_duration) duration_reg <= OD_WDATA[15:0];
      if (wr && hit_tq_range) tq_range_reg <= OD_WDATA[15:0];
      if (wr && hit_ctrl) ctrl_reg <= OD_WDATA[15:0];
      if (wr && hit_halt) halt_opt_reg <= OD_WDATA[15:0];
      if (wr && hit_mode) mode_reg <= OD_WDATA[7:0];
      if (wr && hit_flim) follow_lim_reg <= OD_WDATA;
      if (wr && hit_pthr) pos_thr_reg <= OD_WDATA;
      if (wr && hit_pwin) pos_win_reg <= OD_WDATA[15:0];
      if (wr && hit_tq_tgt) tq_target_reg <= OD_WDATA[15:0];
      if (wr && hit_hofs) home_ofs_reg <= OD_WDATA;
      if (wr && hit_method) method_reg <= OD_WDATA[15:0];
      if (wr && hit_fast) fast_reg <= OD_WDATA[15:0];
      if (wr && hit_slow) slow_reg <= OD_WDATA[15:0];
      if (wr && hit_accel) accel_reg <= OD_WDATA[15:0];
      // timeout code stays until the next start
      if (timed_out)
      begin
        fault_reg <= FAULT_HOME_TIMEOUT;
        HOME_SEARCH_TIMEOUT_ALARM <= 1'b1;
      end
      else if (start_req)
      begin
        fault_reg <= 16'h0;
        HOME_SEARCH_TIMEOUT_ALARM <= 1'b0;
      end
      OD_RDATA <= OD_READ ? rd_mux : OD_RDATA;
      OD_ACK <= (OD_READ & (hit_rw | hit_ro)) | wr;
      // writes to read-only or unknown objects are refused
      OD_ABORT <= (OD_READ & ~(hit_rw | hit_ro)) | (OD_WRITE & ~hit_rw);
      MOTOR_RUN <= enabled;
      SPEED_COMMAND <= speed_next;
      // halt style passed to the motion stage
      HALT_ACTIVE <= halt & enabled;
      HALT_OPTION <= halt_opt_reg;
      TORQUE_REACHED <= tq_reached_reg;
      // position at home becomes zero plus offset
      POSITION_PRESET <= (state_reg == HS_INDEX) && (state_next == HS_DONE);
      POSITION_PRESET_VALUE <= home_ofs_reg;
      STATUS_WORD <= status_next;
    end
  end
endmodule : servo_home_status
